// file: pfr_fail_partner.sv
// fuse driver and one-time memory model answering the failure sequence
`timescale 1ns/100ps
`default_nettype none

module pfr_fail_partner #(
    parameter int DELAY = 3
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // requests from the block
    input  wire logic fuseBlow,
    input  wire logic memoryProgramReq,
    // completion answers
    output logic      fuseBlowDone,
    output logic      memoryProgramDone
);
    int fuseCnt;
    int memCnt;

    // done is a single pulse after a fixed time, never held while idle
    always @(posedge clock) begin
        fuseCnt <= (rst || !fuseBlow) ? 0 : fuseCnt + 1;
        memCnt <= (rst || !memoryProgramReq) ? 0 : memCnt + 1;
        fuseBlowDone <= !rst && fuseBlow && fuseCnt == DELAY;
        memoryProgramDone <= !rst && memoryProgramReq && memCnt == DELAY;
    end
endmodule
`default_nettype wire

// file: pfr_pkg.sv
// shared constants and types of the permanent failure response block
package pfr_pkg;

    // apb register byte offsets
    localparam logic [7:0] ADDR_SAMPLES  = 8'h00;
    localparam logic [7:0] ADDR_PROTCFG  = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_MASK     = 8'h0c;
    localparam logic [7:0] ADDR_COMMAND  = 8'h10;
    localparam logic [7:0] ADDR_STATE    = 8'h14;

    // averaged current sample count
    localparam logic [7:0] SAMPLES_RESET = 8'h50;
    localparam logic [7:0] SAMPLES_MIN   = 8'h02;

    // protection configuration word
    localparam logic [15:0] PROTCFG_RESET = 16'h0002;
    localparam logic [15:0] PROTCFG_MASK  = 16'h07be;
    localparam int BIT_SHORT_CUR_CLR  = 10;
    localparam int BIT_OC_CUR_CLR     = 9;
    localparam int BIT_FUSE_BYPASS    = 8;
    localparam int BIT_FUSE_LOAD_SIDE = 7;
    localparam int BIT_PERSIST_EN     = 5;
    localparam int BIT_FUSE_EN        = 4;
    localparam int BIT_DEEP_SLEEP_EN  = 3;
    localparam int BIT_REG_OFF_EN     = 2;
    localparam int BIT_SWITCH_OFF_EN  = 1;

    // command register bits, write only
    localparam int CMD_SHORT_CLR = 0;
    localparam int CMD_OC_CLR    = 1;
    localparam int CMD_REG_ON    = 2;

    // interrupt status bits
    localparam int IRQ_W         = 5;
    localparam int IRQ_AVG       = 0;
    localparam int IRQ_SHORT     = 1;
    localparam int IRQ_OC        = 2;
    localparam int IRQ_FAIL      = 3;
    localparam int IRQ_SEQ_DONE  = 4;

    // latch recovery time, least time, rounded up to cycles
    localparam int CLOCK_MHZ        = 40;
    localparam int RECOV_TIME_NS    = 1000;
    localparam int RECOV_CYCLES     = (RECOV_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int RC_W             = 16;
    localparam logic [RC_W-1:0] RECOV_LAST = RC_W'(RECOV_CYCLES - 1);

    localparam int ACC_W = 24;

    typedef enum logic [4:0] {
        SEQ_IDLE  = 5'b00001,
        SEQ_FUSE  = 5'b00010,
        SEQ_SAVE  = 5'b00100,
        SEQ_SLEEP = 5'b01000,
        SEQ_DONE  = 5'b10000
    } pfr_seq_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pfr_apb_req_t;

    typedef struct packed {
        logic                failureEvent;
        logic                chargeSwitchFailure;
        logic                dischargeSwitchFailure;
        logic                stackAboveMinBlow;
        logic                loadSideAboveMinBlow;
        logic                fuseBlowDone;
        logic                onetimeMemoryWriteAllow;
        logic                supplyLow;
        logic                temperatureHigh;
        logic                memoryProgramDone;
        logic                partialReset;
    } pfr_fail_in_t;

    typedef struct packed {
        logic [7:0]          sampleCount;
        logic [15:0]         protCfg;
        logic [IRQ_W-1:0]    irqStatus;
        logic [IRQ_W-1:0]    irqMask;
        logic [ACC_W-1:0]    accum;
        logic [7:0]          sampleIdx;
        logic [15:0]         avgCurrent;
        logic                avgValid;
        logic                shortLatch;
        logic                ocLatch;
        logic [RC_W-1:0]     shortCnt;
        logic [RC_W-1:0]     ocCnt;
        pfr_seq_t            seq;
        logic                failStatus;
        logic                ramKept;
        logic                fuseBlow;
        logic                memProgReq;
        logic                deepest_sleep_mode;
        logic                regulatorsOff;
        logic                switchesOff;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                irq;
    } pfr_state_t;

endpackage

// file: pfr_top.sv
// permanent failure response and averaged current logic with apb registers
//
// Behaviour
// R1 - a new averaged current is produced after a programmable 2 to 255 filtered samples, 80 at reset.
// R2 - the short circuit latch clears on load removal or on host command, whatever the current option.
// R3 - with bit 10 set the short latch clears after current holds at recovery level for the recovery time.
// R4 - with bit 9 set the overcurrent latch clears the same way; with it clear current never clears it.
// R5 - with bit 8 set a switch failure with fuse enabled blows the fuse without the voltage check.
// R6 - fuse voltage qualification uses the stack voltage when bit 7 is clear, load side when set.
// R7 - with bit 5 set failure status goes to one-time memory if writes are allowed, else to kept RAM.
// R8 - one-time memory programming waits while supply is low or temperature is high.
// R9 - with bit 5 clear the failure status is lost on any reset, the partial reset included.
// R10 - with bit 4 set a permanent failure blows the fuse once voltage allows; clear never blows it.
// R11 - with bit 3 set a permanent failure ends in deepest sleep, otherwise the power mode stays.
// R12 - deepest sleep waits until enabled fuse blowing and memory saving have finished.
// R13 - with bit 2 set a permanent failure turns the regulators off, otherwise they stay as they are.
// R14 - regulators turned off by a failure come back on by a host command.
// R15 - with bit 1 set, its default, a permanent failure turns the power switches off.
// R16 - power switches turned off by a failure stay off until a full reset.
// R17 - reserved configuration bits are written as zero by the host and ignored here.
`timescale 1ns/100ps
`default_nettype none

module pfr_top (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // apb slave
    input  wire pfr_pkg::pfr_apb_req_t apbReq,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // current measurement
    input  wire logic                  sampleValid,
    input  wire logic [15:0]           filteredCurrentSample,
    output logic [15:0]                averagedCurrent,
    output logic                       averagedCurrentValid,
    // latch faults
    input  wire logic                  shortCircuitTrip,
    input  wire logic                  overcurrentTrip,
    input  wire logic                  loadRemoved,
    input  wire logic                  currentAtShortRecovery,
    input  wire logic                  currentAtOcRecovery,
    output logic                       shortCircuitLatch,
    output logic                       overcurrentLatch,
    // permanent failure
    input  wire pfr_pkg::pfr_fail_in_t failIn,
    output logic                       fuseBlow,
    output logic                       memoryProgramReq,
    output logic                       deepestSleepMode,
    output logic                       regulatorsOff,
    output logic                       switchesOff,
    output logic                       failureStatus,
    // interrupt
    output logic                       irq
);

    pfr_pkg::pfr_state_t s_r;
    pfr_pkg::pfr_state_t s_nxt;

    localparam int IRQ_SET_W = pfr_pkg::IRQ_W;

    logic               acc;
    logic               wrTake;
    logic [31:0]        rdData;
    logic               rdErr;
    logic [15:0]        cfg;
    logic [IRQ_SET_W-1:0] irqSet;
    logic [pfr_pkg::ACC_W-1:0] sumNow;
    logic [pfr_pkg::ACC_W-1:0] quot;
    logic               hostShortClr;
    logic               hostOcClr;
    logic               voltOk;
    logic               fuseGo;

    assign cfg = s_r.protCfg;

    always_comb begin
        s_nxt = s_r;
        irqSet = '0;
        // apb: one wait cycle, then pready; writes land at the pready edge
        acc = apbReq.psel & apbReq.penable;
        wrTake = acc & s_r.pready & apbReq.pwrite;
        s_nxt.pready = acc & ~s_r.pready;
        rdErr = 1'b0;
        unique case (apbReq.paddr)
            pfr_pkg::ADDR_SAMPLES: rdData = {24'h000000, s_r.sampleCount};
            pfr_pkg::ADDR_PROTCFG: rdData = {16'h0000, s_r.protCfg};
            pfr_pkg::ADDR_STATUS:  rdData = {27'h0000000, s_r.irqStatus};
            pfr_pkg::ADDR_MASK:    rdData = {27'h0000000, s_r.irqMask};
            pfr_pkg::ADDR_COMMAND: rdData = 32'h00000000;
            pfr_pkg::ADDR_STATE:   rdData = {s_r.avgCurrent, 1'b0, s_r.seq, 1'b0,
                                             s_r.switchesOff, s_r.regulatorsOff,
                                             s_r.deepest_sleep_mode, s_r.memProgReq, s_r.fuseBlow,
                                             s_r.ramKept, s_r.failStatus,
                                             s_r.ocLatch, s_r.shortLatch};
            default: begin
                rdData = 32'h00000000;
                rdErr = 1'b1;
            end
        endcase
        s_nxt.prdata = (acc & ~s_r.pready & ~apbReq.pwrite) ? rdData : 32'h00000000;
        s_nxt.pslverr = acc & ~s_r.pready & rdErr;

        hostShortClr = 1'b0;
        hostOcClr = 1'b0;
        if (wrTake) begin
            unique case (apbReq.paddr)
                pfr_pkg::ADDR_SAMPLES: begin
                    // counts below two would give no average; clamp
                    s_nxt.sampleCount = (apbReq.pwdata[7:0] < pfr_pkg::SAMPLES_MIN) ?
                                        pfr_pkg::SAMPLES_MIN : apbReq.pwdata[7:0]; // R1
                end
                pfr_pkg::ADDR_PROTCFG: begin
                    s_nxt.protCfg = apbReq.pwdata[15:0] & pfr_pkg::PROTCFG_MASK; // R17
                end
                pfr_pkg::ADDR_STATUS: begin
                    s_nxt.irqStatus = s_r.irqStatus & ~apbReq.pwdata[IRQ_SET_W-1:0];
                end
                pfr_pkg::ADDR_MASK: begin
                    s_nxt.irqMask = apbReq.pwdata[IRQ_SET_W-1:0];
                end
                pfr_pkg::ADDR_COMMAND: begin
                    hostShortClr = apbReq.pwdata[pfr_pkg::CMD_SHORT_CLR];
                    hostOcClr = apbReq.pwdata[pfr_pkg::CMD_OC_CLR];
                    if (apbReq.pwdata[pfr_pkg::CMD_REG_ON]) begin
                        s_nxt.regulatorsOff = 1'b0; // R14
                    end
                end
                default: begin
                end
            endcase
        end

        // averaged current; a count change takes effect at the current window
        s_nxt.avgValid = 1'b0;
        sumNow = s_r.accum + {{8{filteredCurrentSample[15]}}, filteredCurrentSample};
        quot = pfr_pkg::ACC_W'($signed(sumNow) / $signed({1'b0, s_r.sampleCount}));
        if (sampleValid) begin
            if (s_r.sampleIdx + 8'h01 >= s_r.sampleCount) begin
                s_nxt.avgCurrent = quot[15:0]; // R1
                s_nxt.avgValid = 1'b1;
                s_nxt.accum = '0;
                s_nxt.sampleIdx = 8'h00;
                irqSet[pfr_pkg::IRQ_AVG] = 1'b1;
            end else begin
                s_nxt.accum = sumNow;
                s_nxt.sampleIdx = s_r.sampleIdx + 8'h01;
            end
        end

        // short circuit latch: trip wins over any clear in the same cycle
        if (s_r.shortLatch && cfg[pfr_pkg::BIT_SHORT_CUR_CLR] && currentAtShortRecovery) begin
            s_nxt.shortCnt = s_r.shortCnt + 16'h0001; // R3
        end else begin
            s_nxt.shortCnt = '0;
        end
        if (shortCircuitTrip) begin
            s_nxt.shortLatch = 1'b1;
            s_nxt.shortCnt = '0;
            irqSet[pfr_pkg::IRQ_SHORT] = 1'b1;
        end else if (loadRemoved || hostShortClr) begin
            s_nxt.shortLatch = 1'b0; // R2
            s_nxt.shortCnt = '0;
        end else if (s_r.shortLatch && cfg[pfr_pkg::BIT_SHORT_CUR_CLR] &&
                     currentAtShortRecovery && s_r.shortCnt >= pfr_pkg::RECOV_LAST) begin
            s_nxt.shortLatch = 1'b0; // R3
            s_nxt.shortCnt = '0;
        end

        // overcurrent latch, same recovery scheme
        if (s_r.ocLatch && cfg[pfr_pkg::BIT_OC_CUR_CLR] && currentAtOcRecovery) begin
            s_nxt.ocCnt = s_r.ocCnt + 16'h0001; // R4
        end else begin
            s_nxt.ocCnt = '0;
        end
        if (overcurrentTrip) begin
            s_nxt.ocLatch = 1'b1;
            s_nxt.ocCnt = '0;
            irqSet[pfr_pkg::IRQ_OC] = 1'b1;
        end else if (loadRemoved || hostOcClr) begin
            s_nxt.ocLatch = 1'b0;
            s_nxt.ocCnt = '0;
        end else if (s_r.ocLatch && cfg[pfr_pkg::BIT_OC_CUR_CLR] &&
                     currentAtOcRecovery && s_r.ocCnt >= pfr_pkg::RECOV_LAST) begin
            s_nxt.ocLatch = 1'b0; // R4
            s_nxt.ocCnt = '0;
        end

        // failure status lives in volatile state unless persistence is on
        if (failIn.partialReset && !cfg[pfr_pkg::BIT_PERSIST_EN]) begin
            s_nxt.failStatus = 1'b0; // R9
            s_nxt.ramKept = 1'b0;
        end

        voltOk = cfg[pfr_pkg::BIT_FUSE_LOAD_SIDE] ? failIn.loadSideAboveMinBlow :
                                                    failIn.stackAboveMinBlow; // R6
        fuseGo = voltOk || (cfg[pfr_pkg::BIT_FUSE_BYPASS] &&
                 (failIn.chargeSwitchFailure || failIn.dischargeSwitchFailure)); // R5

        // a failure event starts the sequence once; later events still set the status, switch and regulator off
        if (failIn.failureEvent) begin
            s_nxt.failStatus = 1'b1;
            irqSet[pfr_pkg::IRQ_FAIL] = 1'b1;
            if (cfg[pfr_pkg::BIT_SWITCH_OFF_EN]) begin
                s_nxt.switchesOff = 1'b1; // R15
            end
            if (cfg[pfr_pkg::BIT_REG_OFF_EN]) begin
                s_nxt.regulatorsOff = 1'b1; // R13
            end
        end

        unique case (s_r.seq)
            pfr_pkg::SEQ_IDLE: begin
                if (failIn.failureEvent) begin
                    s_nxt.seq = pfr_pkg::SEQ_FUSE;
                end
            end
            pfr_pkg::SEQ_FUSE: begin
                if (!cfg[pfr_pkg::BIT_FUSE_EN]) begin
                    s_nxt.seq = pfr_pkg::SEQ_SAVE; // R10
                end else if (s_r.fuseBlow && failIn.fuseBlowDone) begin
                    s_nxt.fuseBlow = 1'b0;
                    s_nxt.seq = pfr_pkg::SEQ_SAVE;
                end else if (!s_r.fuseBlow && fuseGo) begin
                    s_nxt.fuseBlow = 1'b1; // R10
                end
            end
            pfr_pkg::SEQ_SAVE: begin
                if (!cfg[pfr_pkg::BIT_PERSIST_EN]) begin
                    s_nxt.seq = pfr_pkg::SEQ_SLEEP;
                end else if (!failIn.onetimeMemoryWriteAllow) begin
                    s_nxt.ramKept = 1'b1; // R7
                    s_nxt.seq = pfr_pkg::SEQ_SLEEP;
                end else if (s_r.memProgReq && failIn.memoryProgramDone) begin
                    s_nxt.memProgReq = 1'b0;
                    s_nxt.seq = pfr_pkg::SEQ_SLEEP;
                end else if (!s_r.memProgReq && !failIn.supplyLow &&
                             !failIn.temperatureHigh) begin
                    s_nxt.memProgReq = 1'b1; // R7 R8
                end
            end
            pfr_pkg::SEQ_SLEEP: begin
                // reached only after fuse and save steps are over
                s_nxt.deepest_sleep_mode = cfg[pfr_pkg::BIT_DEEP_SLEEP_EN]; // R11 R12
                s_nxt.seq = pfr_pkg::SEQ_DONE;
                irqSet[pfr_pkg::IRQ_SEQ_DONE] = 1'b1;
            end
            pfr_pkg::SEQ_DONE: begin
                // switches are never released here, only full reset returns them
                s_nxt.seq = pfr_pkg::SEQ_DONE; // R16
            end
            default: begin
                s_nxt.seq = pfr_pkg::SEQ_IDLE;
            end
        endcase

        // set wins over a write-one clear in the same cycle
        s_nxt.irqStatus = s_nxt.irqStatus | irqSet;
        s_nxt.irq = |(s_nxt.irqStatus & s_nxt.irqMask);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
            s_r.sampleCount <= pfr_pkg::SAMPLES_RESET;
            s_r.protCfg <= pfr_pkg::PROTCFG_RESET;
            s_r.seq <= pfr_pkg::SEQ_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign averagedCurrent = s_r.avgCurrent;
    assign averagedCurrentValid = s_r.avgValid;
    assign shortCircuitLatch = s_r.shortLatch;
    assign overcurrentLatch = s_r.ocLatch;
    assign fuseBlow = s_r.fuseBlow;
    assign memoryProgramReq = s_r.memProgReq;
    assign deepestSleepMode = s_r.deepest_sleep_mode;
    assign regulatorsOff = s_r.regulatorsOff;
    assign switchesOff = s_r.switchesOff;
    assign failureStatus = s_r.failStatus;
    assign irq = s_r.irq;

    // checks
    sequence sFailWithSwitchOff;
        failIn.failureEvent && cfg[pfr_pkg::BIT_SWITCH_OFF_EN];
    endsequence

    sequence sSwitchesStayOff;
        switchesOff [*8];
    endsequence

    property p_count_floor;
        @(posedge clock) disable iff (rst)
        s_r.sampleCount >= pfr_pkg::SAMPLES_MIN;
    endproperty
    a_count_floor: assert property (p_count_floor) // R1
        else $error("sample count below two");

    property p_short_load_clear;
        @(posedge clock) disable iff (rst)
        shortCircuitLatch && loadRemoved && !shortCircuitTrip |=> !shortCircuitLatch;
    endproperty
    a_short_load_clear: assert property (p_short_load_clear) // R2
        else $error("short latch not cleared by load removal");

    property p_short_no_current_clear;
        @(posedge clock) disable iff (rst)
        shortCircuitLatch && !cfg[pfr_pkg::BIT_SHORT_CUR_CLR] && !loadRemoved
            && !hostShortClr |=> shortCircuitLatch;
    endproperty
    a_short_no_current_clear: assert property (p_short_no_current_clear) // R3
        else $error("short latch cleared with current recovery off");

    property p_oc_no_current_clear;
        @(posedge clock) disable iff (rst)
        overcurrentLatch && !cfg[pfr_pkg::BIT_OC_CUR_CLR] && !loadRemoved
            && !hostOcClr |=> overcurrentLatch;
    endproperty
    a_oc_no_current_clear: assert property (p_oc_no_current_clear) // R4
        else $error("overcurrent latch cleared with current recovery off");

    property p_fuse_needs_enable;
        @(posedge clock) disable iff (rst)
        $rose(fuseBlow) |-> $past(cfg[pfr_pkg::BIT_FUSE_EN]) && $past(fuseGo);
    endproperty
    a_fuse_needs_enable: assert property (p_fuse_needs_enable) // R10
        else $error("fuse blown without enable or voltage");

    property p_program_conditions;
        @(posedge clock) disable iff (rst)
        $rose(memoryProgramReq) |-> $past(!failIn.supplyLow && !failIn.temperatureHigh);
    endproperty
    a_program_conditions: assert property (p_program_conditions) // R8
        else $error("memory programming started under bad conditions");

    property p_sleep_after_actions;
        @(posedge clock) disable iff (rst)
        $rose(deepestSleepMode) |-> !fuseBlow && !memoryProgramReq
            && $past(cfg[pfr_pkg::BIT_DEEP_SLEEP_EN]);
    endproperty
    a_sleep_after_actions: assert property (p_sleep_after_actions) // R12
        else $error("deep sleep entered too early");

    property p_regs_off;
        @(posedge clock) disable iff (rst)
        failIn.failureEvent && cfg[pfr_pkg::BIT_REG_OFF_EN] |=> regulatorsOff;
    endproperty
    a_regs_off: assert property (p_regs_off) // R13
        else $error("regulators not turned off on failure");

    property p_switches_off_hold;
        @(posedge clock) disable iff (rst)
        sFailWithSwitchOff |=> sSwitchesStayOff;
    endproperty
    a_switches_off_hold: assert property (p_switches_off_hold) // R15 R16
        else $error("power switches not held off after failure");

    property p_status_discard;
        @(posedge clock) disable iff (rst)
        failIn.partialReset && !cfg[pfr_pkg::BIT_PERSIST_EN] && !failIn.failureEvent
            |=> !failureStatus;
    endproperty
    a_status_discard: assert property (p_status_discard) // R9
        else $error("failure status survived partial reset");

endmodule

`default_nettype wire

// file: test_pfr_top.sv
// self-checking testbench of the permanent failure response block
`timescale 1ns/100ps
`default_nettype none

module test_pfr_top;
    logic                  clock = 0;
    logic                  rst = 1;
    pfr_pkg::pfr_apb_req_t req = '0;
    pfr_pkg::pfr_fail_in_t fin = '0;
    pfr_pkg::pfr_fail_in_t failIn;
    logic [31:0] prdata;
    logic        pready, pslverr, sampleValid = 0, avgValid, shortTrip = 0, ocTrip = 0;
    logic        loadRemoved = 0, curShort = 0, curOc = 0, shortLatch, ocLatch;
    logic        fuseBlow, memReq, deepest_sleep_mode, regsOff, swOff, failStatus, irq;
    logic        fuseDone, memDone, sawFuse = 0, sawMem = 0;
    logic [15:0] sample = '0;
    logic [15:0] avg;
    logic [33:0] notes[$];
    logic [33:0] e;
    int          err_count = 0, total_checks = 0, seed = 19370, sum, n, k;

    always #12.5 clock = ~clock;

    always_comb begin
        failIn = fin;
        failIn.fuseBlowDone = fuseDone;
        failIn.memoryProgramDone = memDone;
    end

    pfr_top i_dut (.clock(clock), .rst(rst), .apbReq(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleValid(sampleValid), .filteredCurrentSample(sample),
        .averagedCurrent(avg), .averagedCurrentValid(avgValid), .shortCircuitTrip(shortTrip),
        .overcurrentTrip(ocTrip), .loadRemoved(loadRemoved), .currentAtShortRecovery(curShort),
        .currentAtOcRecovery(curOc), .shortCircuitLatch(shortLatch),
        .overcurrentLatch(ocLatch), .failIn(failIn), .fuseBlow(fuseBlow),
        .memoryProgramReq(memReq), .deepestSleepMode(deepest_sleep_mode), .regulatorsOff(regsOff),
        .switchesOff(swOff), .failureStatus(failStatus), .irq(irq));

    pfr_fail_partner i_far (.clock(clock), .rst(rst), .fuseBlow(fuseBlow),
        .memoryProgramReq(memReq), .fuseBlowDone(fuseDone), .memoryProgramDone(memDone));

    task automatic check(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            err_count++;
            $display("Error %0t seen %h expected %h", $time, s, x);
        end
    endtask

    // one apb transfer; the note holds read flag, expected error and data
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        notes.push_back({!wr, a > pfr_pkg::ADDR_STATE, d});
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // output watcher: every answer is matched against the oldest note
    always @(posedge clock) begin
        if (pready === 1'b1 && notes.size() > 0) begin
            e = notes.pop_front();
            check(32'(pslverr), 32'(e[32]));
            if (e[33]) check(prdata, e[31:0]);
        end
        if (fuseBlow) sawFuse <= 1;
        if (memReq) sawMem <= 1;
    end

    task automatic waitCycles(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic summarize;
        if (err_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        waitCycles(20000);
        err_count++;
        summarize();
    end

    initial begin
        waitCycles(5);
        rst <= 0;
        apb(0, pfr_pkg::ADDR_SAMPLES, 32'h0000_0050);
        apb(0, pfr_pkg::ADDR_PROTCFG, 32'h0000_0002);
        apb(0, 8'h3c, 32'h0000_0000);
        apb(1, pfr_pkg::ADDR_PROTCFG, 32'h0000_ffff);
        apb(0, pfr_pkg::ADDR_PROTCFG, 32'h0000_07be);
        apb(1, pfr_pkg::ADDR_SAMPLES, 32'h0000_0001);
        apb(0, pfr_pkg::ADDR_SAMPLES, 32'h0000_0002);
        apb(1, pfr_pkg::ADDR_SAMPLES, 32'h0000_0003);
        sum = 0;
        for (k = 0; k < 3; k++) begin
            @(posedge clock);
            sample <= 16'($random(seed));
            sampleValid <= 1;
            @(posedge clock);
            sampleValid <= 0;
            sum += int'($signed(sample));
        end
        for (n = 0; n < 20 && avgValid !== 1'b1; n++) @(posedge clock);
        check(32'(avgValid), 32'h1);
        check(32'(avg), 32'(16'(sum / 3)));
        // current clearing enabled, then disabled, for both latches
        for (k = 0; k < 2; k++) begin
            apb(1, pfr_pkg::ADDR_PROTCFG, k == 0 ? 32'h0000_0600 : 32'h0000_0000);
            ocTrip <= 1;
            shortTrip <= 1;
            @(posedge clock);
            ocTrip <= 0;
            shortTrip <= 0;
            curOc <= 1;
            curShort <= 1;
            waitCycles(30);
            check(32'({shortLatch, ocLatch}), 32'h3);
            waitCycles(20);
            check(32'({shortLatch, ocLatch}), k == 0 ? 32'h0 : 32'h3);
            curOc <= 0;
            curShort <= 0;
        end
        apb(1, pfr_pkg::ADDR_COMMAND, 32'h0000_0003);
        @(posedge clock);
        check(32'({shortLatch, ocLatch}), 32'h0);
        shortTrip <= 1;
        @(posedge clock);
        shortTrip <= 0;
        @(posedge clock);
        check(32'(shortLatch), 32'h1);
        loadRemoved <= 1;
        waitCycles(2);
        loadRemoved <= 0;
        check(32'(shortLatch), 32'h0);
        // full failure sequence with every action enabled
        apb(1, pfr_pkg::ADDR_PROTCFG, 32'h0000_003e);
        fin.stackAboveMinBlow <= 1;
        fin.onetimeMemoryWriteAllow <= 1;
        fin.failureEvent <= 1;
        @(posedge clock);
        fin.failureEvent <= 0;
        waitCycles(2);
        check({swOff, regsOff, failStatus}, 32'h7);
        for (n = 0; n < 200 && deepest_sleep_mode !== 1'b1; n++) @(posedge clock);
        check({sawFuse, sawMem, deepest_sleep_mode}, 32'h7);
        apb(1, pfr_pkg::ADDR_COMMAND, 32'h0000_0004);
        waitCycles(2);
        check({swOff, regsOff}, 32'h2);
        apb(0, pfr_pkg::ADDR_STATUS, 32'h0000_001f);
        apb(1, pfr_pkg::ADDR_MASK, 32'h0000_001f);
        @(posedge clock);
        check(32'(irq), 32'h1);
        apb(1, pfr_pkg::ADDR_MASK, 32'h0000_0000);
        @(posedge clock);
        check(32'(irq), 32'h0);
        apb(1, pfr_pkg::ADDR_STATUS, 32'h0000_001f);
        apb(0, pfr_pkg::ADDR_STATUS, 32'h0000_0000);
        // persistence off: a partial reset drops the failure status
        apb(1, pfr_pkg::ADDR_PROTCFG, 32'h0000_0000);
        fin.partialReset <= 1;
        waitCycles(2);
        fin.partialReset <= 0;
        check(32'(failStatus), 32'h0);
        waitCycles(3);
        summarize();
    end
endmodule
`default_nettype wire
